//--- shared/sword_pkg.sv
// Constants, types and the rule overview for the serial word address decoder.
// Overview of operation
// - A latched word ending in 011 goes to the third configuration word.
// - A latched word ending in 0111 goes to the fourth configuration word.
// - A latched word ending in 01111 goes to the fifth configuration word.
// - Words three to five are written only while default_word_select is 0.
// - A latched word ending in 10 goes to the second configuration word.
// - A latched word ending in 01 goes to the first word, holding default_word_select.
// - With default_word_select at 1 the second word uses its built-in default.
package sword_pkg;
    localparam int WORD_W = 24;
    localparam int DEF_SEL_POS = 23;
    localparam logic [1:0] ADDR_ONE = 2'h1;
    localparam logic [1:0] ADDR_TWO = 2'h2;
    localparam logic [2:0] ADDR_THREE = 3'h3;
    localparam logic [3:0] ADDR_FOUR = 4'h7;
    localparam logic [4:0] ADDR_FIVE = 5'h0f;
    localparam logic [23:0] RST_ONE = 24'h928101;
    localparam logic [23:0] RST_TWO = 24'hc87806;
    localparam logic [23:0] RST_THREE = 24'h86801b;
    localparam logic [23:0] RST_FOUR = 24'h03a327;
    localparam logic [23:0] RST_FIVE = 24'h00000f;

    typedef enum logic [2:0] {
        TGT_NONE = 3'b000,
        TGT_ONE = 3'b001,
        TGT_TWO = 3'b011,
        TGT_THREE = 3'b010,
        TGT_FOUR = 3'b110,
        TGT_FIVE = 3'b111
    } target_t;

    typedef struct packed {
        logic [23:0] one;
        logic [23:0] two;
        logic [23:0] three;
        logic [23:0] four;
        logic [23:0] five;
    } cfg_bank_t;
endpackage

//--- design/sword_sync2.sv
// Two-flop level synchroniser into the system clock domain.
`timescale 1ns/100ps
module sword_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

//--- design/serial_word_address_decoder.sv
// Serial configuration word receiver with address decode and default selection.
`timescale 1ns/100ps
module serial_word_address_decoder
    import sword_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SER_CLK,
    input wire logic SER_DATA,
    input wire logic LATCH_EN,
    output cfg_bank_t CFG_ACTIVE,
    output logic DEFAULT_SELECT,
    output logic WORD_TAKEN,
    output logic WORD_REFUSED
);
    // Returns which configuration word a latched word addresses.
    function automatic target_t decode_target(input logic [WORD_W-1:0] w);
        target_t t;
        t = TGT_NONE;
        if (w[1:0] == ADDR_ONE) begin
            t = TGT_ONE;
        end else if (w[1:0] == ADDR_TWO) begin
            t = TGT_TWO;
        end else if (w[2:0] == ADDR_THREE) begin
            t = TGT_THREE;
        end else if (w[3:0] == ADDR_FOUR) begin
            t = TGT_FOUR;
        end else if (w[4:0] == ADDR_FIVE) begin
            t = TGT_FIVE;
        end
        return t;
    endfunction

    // Link domain: the shifter only ever sees serial clock edges, so it keeps
    // the last 24 bits shifted; longer bursts simply push older bits out.
    logic [WORD_W-1:0] shift_q;

    always_ff @(posedge SER_CLK or negedge RESETN) begin
        if (!RESETN) begin
            shift_q <= '0;
        end else begin
            shift_q <= {shift_q[WORD_W-2:0], SER_DATA};
        end
    end

    // The latch pulse is the request of the crossing: the serial clock stands
    // still while it is high, so the shifter is stable when it is sampled.
    logic latch_sync;
    logic latch_prev_q;
    logic [WORD_W-1:0] word_q;
    logic word_valid_q;

    sword_sync2 u_latch_sync (
        .clk(CLK),
        .rst_n(RESETN),
        .async_in(LATCH_EN),
        .sync_out(latch_sync)
    );

    wire latch_rise = latch_sync & ~latch_prev_q;

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            latch_prev_q <= 1'b0;
            word_q <= '0;
            word_valid_q <= 1'b0;
        end else begin
            latch_prev_q <= latch_sync;
            word_valid_q <= latch_rise;
            if (latch_rise) begin
                word_q <= shift_q;
            end
        end
    end

    // Register bank in the system domain.
    cfg_bank_t cfg_q;
    cfg_bank_t cfg_d;
    wire target_t target = decode_target(word_q);
    wire def_sel = cfg_q.one[DEF_SEL_POS];
    wire upper_open = ~def_sel;
    wire wr_one = word_valid_q && (target == TGT_ONE);
    wire wr_two = word_valid_q && (target == TGT_TWO);
    wire wr_three = word_valid_q && (target == TGT_THREE) && upper_open;
    wire wr_four = word_valid_q && (target == TGT_FOUR) && upper_open;
    wire wr_five = word_valid_q && (target == TGT_FIVE) && upper_open;
    wire taken = wr_one | wr_two | wr_three | wr_four | wr_five;
    wire refused = word_valid_q & ~taken;

    always_comb begin
        cfg_d = cfg_q;
        if (wr_one) begin
            cfg_d.one = word_q;
        end
        if (wr_two) begin
            cfg_d.two = word_q;
        end
        if (wr_three) begin
            cfg_d.three = word_q;
        end
        if (wr_four) begin
            cfg_d.four = word_q;
        end
        if (wr_five) begin
            cfg_d.five = word_q;
        end
    end

    // Outputs show what the synthesizer actually runs from, not raw storage.
    cfg_bank_t active_d;

    always_comb begin
        active_d = cfg_q;
        if (def_sel) begin
            active_d.two = RST_TWO;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            cfg_q <= '{one: RST_ONE, two: RST_TWO, three: RST_THREE,
                       four: RST_FOUR, five: RST_FIVE};
            CFG_ACTIVE <= '{one: RST_ONE, two: RST_TWO, three: RST_THREE,
                            four: RST_FOUR, five: RST_FIVE};
            DEFAULT_SELECT <= RST_ONE[DEF_SEL_POS];
            WORD_TAKEN <= 1'b0;
            WORD_REFUSED <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            CFG_ACTIVE <= active_d;
            DEFAULT_SELECT <= def_sel;
            WORD_TAKEN <= taken;
            WORD_REFUSED <= refused;
        end
    end
endmodule

//--- dv/serial_word_address_decoder_properties.sv
// Assertion checker for the serial word address decoder ports.
`timescale 1ns/100ps
module sword_props
    import sword_pkg::*;
(
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic LATCH_EN,
    input cfg_bank_t CFG_ACTIVE,
    input wire logic DEFAULT_SELECT,
    input wire logic WORD_TAKEN,
    input wire logic WORD_REFUSED
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    AST_ONE: assert property ($changed(CFG_ACTIVE.one)
        |-> CFG_ACTIVE.one[1:0] == ADDR_ONE)
        else $error("word one stored under a wrong address");
    AST_TWO: assert property (!DEFAULT_SELECT && $changed(CFG_ACTIVE.two)
        |-> CFG_ACTIVE.two[1:0] == ADDR_TWO)
        else $error("word two stored under a wrong address");
    AST_THREE: assert property ($changed(CFG_ACTIVE.three)
        |-> CFG_ACTIVE.three[2:0] == ADDR_THREE)
        else $error("word three stored under a wrong address");
    AST_FOUR: assert property ($changed(CFG_ACTIVE.four)
        |-> CFG_ACTIVE.four[3:0] == ADDR_FOUR)
        else $error("word four stored under a wrong address");
    AST_FIVE: assert property ($changed(CFG_ACTIVE.five)
        |-> CFG_ACTIVE.five[4:0] == ADDR_FIVE)
        else $error("word five stored under a wrong address");
    AST_GATE: assert property ($past(DEFAULT_SELECT) |-> $stable(CFG_ACTIVE[71:0]))
        else $error("upper word written while defaults selected");
    AST_DEFS: assert property (DEFAULT_SELECT
        |-> CFG_ACTIVE.two == RST_TWO && CFG_ACTIVE.one[DEF_SEL_POS])
        else $error("default word two not in use");
    AST_ANSWER: assert property ($rose(LATCH_EN)
        |-> ##[3:8] (WORD_TAKEN || WORD_REFUSED))
        else $error("latched word got no answer");
    // The bank output is registered from storage, so it trails the stored-word pulse by a clock.
    AST_QUIET: assert property ($changed(CFG_ACTIVE) |-> $past(WORD_TAKEN))
        else $error("bank changed without a stored word");
    cover property (WORD_REFUSED);
    cover property ($changed(CFG_ACTIVE.five));
    cover property ($fell(DEFAULT_SELECT));
endmodule
bind serial_word_address_decoder sword_props u_props (.CLK, .RESETN, .LATCH_EN, .CFG_ACTIVE,
    .DEFAULT_SELECT, .WORD_TAKEN, .WORD_REFUSED);

//--- dv/sword_host.sv
// Host model that shifts words over the serial link and pulses latch enable.
`timescale 1ns/100ps
module sword_host (
    input wire logic clk,
    output logic ser_clk,
    output logic ser_data,
    output logic latch_en
);
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        latch_en = 1'b0;
    end
    // The link clock only runs inside a frame, as a real host would leave it.
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            ser_data = w[i];
            #80 ser_clk = 1'b1;
            #80 ser_clk = 1'b0;
        end
        ser_data = ~w[0];
        @(posedge clk) latch_en <= 1'b1;
        repeat (3) @(posedge clk);
        latch_en <= 1'b0;
    endtask
endmodule

//--- dv/serial_word_address_decoder_test.sv
// Self-checking testbench for the serial word address decoder.
`timescale 1ns/100ps
module serial_word_address_decoder_test;
    import sword_pkg::*;
    logic CLK = 1'b0;
    logic RESETN = 1'b0;
    wire SER_CLK, SER_DATA, LATCH_EN;
    cfg_bank_t CFG_ACTIVE;
    logic DEFAULT_SELECT, WORD_TAKEN, WORD_REFUSED;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic [23:0] up [3] = '{24'habcdeb, 24'h765437, 24'h33330f};
    initial forever #2.5 CLK = ~CLK;
    sword_host host (.clk(CLK), .ser_clk(SER_CLK), .ser_data(SER_DATA), .latch_en(LATCH_EN));
    serial_word_address_decoder DUT (.CLK(CLK), .RESETN(RESETN), .SER_CLK(SER_CLK),
        .SER_DATA(SER_DATA), .LATCH_EN(LATCH_EN), .CFG_ACTIVE(CFG_ACTIVE),
        .DEFAULT_SELECT(DEFAULT_SELECT), .WORD_TAKEN(WORD_TAKEN), .WORD_REFUSED(WORD_REFUSED));
    task automatic end_sim();
        if (bad_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(string n, logic [23:0] e, logic [23:0] s);
        cmp_count++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // Outputs are read on the falling edge so they never race the update edge.
    task automatic put(logic [23:0] w, logic tk);
        int n;
        n = 0;
        host.send(w);
        while (WORD_TAKEN !== 1'b1 && WORD_REFUSED !== 1'b1 && n < 20) begin
            @(negedge CLK);
            n++;
        end
        chk("answer", {22'h0, ~tk, tk}, {22'h0, WORD_REFUSED, WORD_TAKEN});
        repeat (4) @(negedge CLK);
    endtask
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(posedge CLK);
        RESETN <= 1'b1;
        repeat (3) @(negedge CLK);
        chk("one", RST_ONE, CFG_ACTIVE.one);
        chk("sel", 24'h1, {23'h0, DEFAULT_SELECT});
        put(24'h123456, 1'b1);
        chk("two", RST_TWO, CFG_ACTIVE.two);
        put(up[0], 1'b0);
        chk("three", RST_THREE, CFG_ACTIVE.three);
        put(24'h012345, 1'b1);
        chk("sel", 24'h0, {23'h0, DEFAULT_SELECT});
        chk("one", 24'h012345, CFG_ACTIVE.one);
        chk("two", 24'h123456, CFG_ACTIVE.two);
        for (int i = 0; i < 3; i++) begin
            put(up[i], 1'b1);
            chk("upper", up[i], CFG_ACTIVE[(2 - i) * 24 +: 24]);
        end
        put(24'h000000, 1'b0);
        put(24'h00001f, 1'b0);
        put(24'h800001, 1'b1);
        chk("two", RST_TWO, CFG_ACTIVE.two);
        put(24'h11110f, 1'b0);
        chk("five", 24'h33330f, CFG_ACTIVE.five);
        end_sim();
    end
endmodule
